// ===== src/pwr_consts.svh
// Constants for the module power control block: offsets, fields, resets, timing
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_CMD           8'h04
`define REG_STATUS        8'h08
`define REG_FAN_RPM       8'h0c
`define REG_WDT           8'h10

// Control register fields
`define CTRL_POLICY_LSB   0
`define CTRL_RAIL_BIT     2
`define CTRL_BTNSW_BIT    3
`define CTRL_DUTY_LSB     8
`define CTRL_RESET        32'h0000_8004

// Status register fields
`define STAT_STATE_LSB    0
`define STAT_LAST_ON_BIT  3
`define STAT_LOSS_BIT     4
`define STAT_BTN_BIT      5
`define STAT_MON_BIT      6
`define STAT_WARN_BIT     7

// Watchdog register fields
`define WDT_EN_BIT        0
`define WDT_TIMEOUT_LSB   16
`define WDT_RESET         32'h0000_0000

// Timing
`define CLK_HZ            64'd100000000
`define CLK_PERIOD_NS     64'd10
`define MONITOR_TIME_S    64'd30
`define MS_PER_S          64'd1000
`define RPM_WINDOW_S      64'd1
`define SEC_PER_MIN       64'd60
`define TACH_PULSES_REV   64'd2
`define FILTER_TIME_NS    64'd1000
`define TACH_FILTER       8'h02
`define PWM_DIV           8'h10

`endif

// ===== src/pwr_pkg.sv
// Types shared by the module power control block
package pwr_pkg;

  // Power states of the module
  typedef enum logic [2:0] {
    PS_G3    = 3'h0,
    PS_OFF   = 3'h1,
    PS_ON    = 3'h2,
    PS_SLEEP = 3'h3,
    PS_DEEP  = 3'h4,
    PS_ESOFF = 3'h5
  } pstate_t;

  // Restore policy after standby returns
  typedef enum logic [1:0] {
    POL_OFF  = 2'h0,
    POL_ON   = 2'h1,
    POL_LAST = 2'h2
  } policy_t;

  // Software commands
  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_SHUTDOWN = 3'h1,
    CMD_SLEEP    = 3'h2,
    CMD_DEEP     = 3'h3,
    CMD_ESOFF    = 3'h4,
    CMD_KICK     = 3'h5
  } cmd_t;

endpackage

// ===== src/sync_filter.sv
// Three-stage synchroniser with a stability filter for one pin
`timescale 1ns/1ps
`default_nettype none

module sync_filter #(
  parameter logic [7:0] FILT_LEN = 8'h01,
  parameter logic       INIT     = 1'b0
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);

  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic [7:0] cnt_r;
  logic       differs;

  // Second and third stages agree on a level other than the output
  assign differs = (s2_r == s3_r) && (s3_r != dout);

  // Synchroniser chain; the first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Stability counter; any disagreement restarts it so glitches die here
  always_ff @(posedge mclk)
  begin
    if (reset)
      cnt_r <= 8'h00;
    else if (differs && cnt_r != FILT_LEN - 8'h01)
      cnt_r <= cnt_r + 8'h01;
    else
      cnt_r <= 8'h00;
  end

  // Filtered output
  always_ff @(posedge mclk)
  begin
    if (reset)
      dout <= INIT;
    else if (differs && cnt_r == FILT_LEN - 8'h01)
      dout <= s3_r;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_filter_agree: assert property ($changed(dout) |-> $past(s2_r == s3_r))
    else $error("filtered output changed without stage agreement");

  c_filter_change: cover property ($changed(dout));

endmodule // sync_filter

`default_nettype wire

// ===== src/module_power_control.sv
// Power sequencing, restore policy, sleep states, watchdog and fan control
//
// Contract
// - Module reset stays asserted while power good is low; boot follows release.
// - An undriven power good reads high and counts as released; here it has no pull-up and stays at its low reset level.
// - Active-low supply-on output requests the main supply outputs on.
// - A power button press toggles power; its effect depends on configuration.
// - After shutdown, thirty stable standby seconds mean proper off; loss means power loss.
// - On standby return apply policy: turn on, stay off, or restore last state.
// - The thirty second monitor runs only under the restore-last-state policy.
// - Loss inside the monitor after a regular shutdown leaves last state on.
// - Restore policies have no effect without a standby rail.
// - Fan drive output is a pulse-width-modulated fan speed control.
// - Fan speed is computed assuming two tach pulses per revolution.
// - Wake from deep sleep returns to the state deep sleep was entered from.
// - Enhanced soft-off wakes only on power button, sleep button, bus alert.
// - Multi-stage software-serviced watchdog with no non-maskable interrupt action.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_consts.svh"

module module_power_control #(
  parameter logic [31:0] MONITOR_CYCLES = 32'(`MONITOR_TIME_S * `CLK_HZ),
  parameter logic [31:0] MS_CYCLES      = 32'(`CLK_HZ / `MS_PER_S),
  parameter logic [31:0] RPM_WINDOW     = 32'(`RPM_WINDOW_S * `CLK_HZ)
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        standby_ok,
  input  wire logic        power_good_input,
  input  wire logic        power_button_n,
  input  wire logic        sleep_button_n,
  input  wire logic        smbus_alert_n,
  input  wire logic        wake_in,
  input  wire logic        fan_speed_in,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             supply_on_n,
  output logic             module_reset_n,
  output logic             fan_drive_out
);

  localparam int          NPIN      = 6;
  localparam logic [5:0]  PIN_INIT  = 6'h0e; // Idle levels: standby, power good, wake low
  localparam logic [7:0]  FILT_CYC  = 8'(`FILTER_TIME_NS / `CLK_PERIOD_NS);
  localparam logic [15:0] RPM_SCALE = 16'(`SEC_PER_MIN / (`RPM_WINDOW_S * `TACH_PULSES_REV));

  logic [NPIN-1:0]  pins;
  logic [NPIN-1:0]  filt;
  logic [NPIN-1:0]  filt_prev_r;
  logic             tach_f;
  logic             tach_prev_r;
  logic             sb_f;
  logic             pg_f;
  logic             btn_press;
  logic             slp_press;
  logic             alert_fall;
  logic             wake_rise;
  logic [31:0]      ctrl_r;
  logic [31:0]      wdt_ctrl_r;
  logic             wr_cmd;
  pwr_pkg::cmd_t    cmd;
  pwr_pkg::policy_t policy;
  logic             rail_en;
  pwr_pkg::pstate_t state_r;
  pwr_pkg::pstate_t state_nxt;
  logic             deep_from_sleep_r;
  logic             last_on_r;
  logic             loss_r;
  logic             btn_evt_r;
  logic             mon_active_r;
  logic [31:0]      mon_cnt_r;
  logic             shutdown_evt;
  logic [31:0]      ms_cnt_r;
  logic             ms_tick;
  logic [15:0]      wdt_cnt_r;
  logic             wdt_stage2_r;
  logic             wdt_warn_r;
  logic             wdt_fire_r;
  logic             wdt_run;
  logic [7:0]       pwm_div_r;
  logic [7:0]       pwm_cnt_r;
  logic [31:0]      win_cnt_r;
  logic [15:0]      pulse_cnt_r;
  logic [15:0]      rpm_r;

  // States in which the host is powered and a power loss is a real loss
  function automatic logic is_powered(input pwr_pkg::pstate_t s);
    is_powered = (s == pwr_pkg::PS_ON) || (s == pwr_pkg::PS_SLEEP);
  endfunction

  // Pin order: standby, power good, power button, sleep button, alert, wake
  assign pins = {standby_ok, power_good_input, power_button_n,
                 sleep_button_n, smbus_alert_n, wake_in};

  // Each of the six pins passes the same synchroniser and filter
  generate
    for (genvar gi = 0; gi < NPIN; gi++)
    begin : g_pin
      sync_filter #(
        .FILT_LEN (FILT_CYC),
        .INIT     (PIN_INIT[gi])
      ) u_filt (
        .mclk  (mclk),
        .reset (reset),
        .din   (pins[gi]),
        .dout  (filt[gi])
      );
    end
  endgenerate

  // Tach needs a short filter only, pulses are fast
  sync_filter #(
    .FILT_LEN (`TACH_FILTER),
    .INIT     (1'b1)
  ) u_tach (
    .mclk  (mclk),
    .reset (reset),
    .din   (fan_speed_in),
    .dout  (tach_f)
  );

  // Edge detection on filtered pins
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      filt_prev_r <= PIN_INIT;
      tach_prev_r <= 1'b1;
    end
    else
    begin
      filt_prev_r <= filt;
      tach_prev_r <= tach_f;
    end
  end

  assign sb_f       = filt[5];
  assign pg_f       = filt[4];
  assign btn_press  = filt_prev_r[3] && !filt[3];
  assign slp_press  = filt_prev_r[2] && !filt[2];
  assign alert_fall = filt_prev_r[1] && !filt[1];
  assign wake_rise  = !filt_prev_r[0] && filt[0];

  assign wr_cmd  = wr && (addr == `REG_CMD);
  assign cmd     = wr_cmd ? pwr_pkg::cmd_t'(wdata[2:0]) : pwr_pkg::CMD_NONE;
  assign policy  = pwr_pkg::policy_t'(ctrl_r[`CTRL_POLICY_LSB +: 2]);
  assign rail_en = ctrl_r[`CTRL_RAIL_BIT];

  // Configuration registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r     <= `CTRL_RESET;
      wdt_ctrl_r <= `WDT_RESET;
    end
    else if (wr && addr == `REG_CTRL)
      ctrl_r <= wdata;
    else if (wr && addr == `REG_WDT)
      wdt_ctrl_r <= wdata;
  end

  // Power state sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      pwr_pkg::PS_G3:
        if (sb_f)
        begin
          if (!rail_en)
            state_nxt = pwr_pkg::PS_ON;
          else if (policy == pwr_pkg::POL_ON)
            state_nxt = pwr_pkg::PS_ON;
          else if (policy == pwr_pkg::POL_LAST && last_on_r)
            state_nxt = pwr_pkg::PS_ON;
          else
            state_nxt = pwr_pkg::PS_OFF;
        end
      pwr_pkg::PS_OFF:
        if (btn_press)
          state_nxt = pwr_pkg::PS_ON;
        else if (cmd == pwr_pkg::CMD_ESOFF)
          state_nxt = pwr_pkg::PS_ESOFF;
        else if (cmd == pwr_pkg::CMD_DEEP)
          state_nxt = pwr_pkg::PS_DEEP;
      pwr_pkg::PS_ON:
        if (cmd == pwr_pkg::CMD_SHUTDOWN || (btn_press && !ctrl_r[`CTRL_BTNSW_BIT]))
          state_nxt = pwr_pkg::PS_OFF;
        else if (cmd == pwr_pkg::CMD_SLEEP)
          state_nxt = pwr_pkg::PS_SLEEP;
      pwr_pkg::PS_SLEEP:
        if (btn_press || slp_press || wake_rise)
          state_nxt = pwr_pkg::PS_ON;
        else if (cmd == pwr_pkg::CMD_DEEP)
          state_nxt = pwr_pkg::PS_DEEP;
      pwr_pkg::PS_DEEP:
        if (btn_press || wake_rise)
          state_nxt = deep_from_sleep_r ? pwr_pkg::PS_SLEEP : pwr_pkg::PS_OFF;
      pwr_pkg::PS_ESOFF:
        if (btn_press || slp_press || alert_fall)
          state_nxt = pwr_pkg::PS_ON;
    endcase
    if (!sb_f)
      state_nxt = pwr_pkg::PS_G3;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state_r <= pwr_pkg::PS_G3;
    else
      state_r <= state_nxt;
  end

  // Remember where deep sleep was entered from
  always_ff @(posedge mclk)
  begin
    if (reset)
      deep_from_sleep_r <= 1'b0;
    else if (state_r != pwr_pkg::PS_DEEP && state_nxt == pwr_pkg::PS_DEEP)
      deep_from_sleep_r <= (state_r == pwr_pkg::PS_SLEEP);
  end

  assign shutdown_evt = (state_r == pwr_pkg::PS_ON) && (state_nxt == pwr_pkg::PS_OFF);

  // Standby monitor after a shutdown; only the last-state policy needs it
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mon_active_r <= 1'b0;
      mon_cnt_r    <= 32'h0000_0000;
    end
    else if (shutdown_evt)
    begin
      mon_active_r <= rail_en && (policy == pwr_pkg::POL_LAST);
      mon_cnt_r    <= 32'h0000_0000;
    end
    else if (mon_active_r && (!sb_f || mon_cnt_r == MONITOR_CYCLES - 32'h1))
      mon_active_r <= 1'b0;
    else if (mon_active_r)
      mon_cnt_r <= mon_cnt_r + 32'h1;
  end

  // Last state record; a loss inside the monitor keeps it on as shipped
  always_ff @(posedge mclk)
  begin
    if (reset)
      last_on_r <= 1'b0;
    else if (state_r == pwr_pkg::PS_ON)
      last_on_r <= 1'b1;
    else if (shutdown_evt && !(rail_en && policy == pwr_pkg::POL_LAST))
      last_on_r <= 1'b0;
    else if (mon_active_r && sb_f && mon_cnt_r == MONITOR_CYCLES - 32'h1)
      last_on_r <= 1'b0;
    else if (state_r == pwr_pkg::PS_OFF && !mon_active_r)
      last_on_r <= 1'b0;
  end

  // Sticky loss and button flags, write one to clear; a new event wins
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      loss_r    <= 1'b0;
      btn_evt_r <= 1'b0;
    end
    else
    begin
      if (!sb_f && (is_powered(state_r) || mon_active_r))
        loss_r <= 1'b1;
      else if (wr && addr == `REG_STATUS && wdata[`STAT_LOSS_BIT])
        loss_r <= 1'b0;
      if (btn_press && state_r == pwr_pkg::PS_ON && ctrl_r[`CTRL_BTNSW_BIT])
        btn_evt_r <= 1'b1;
      else if (wr && addr == `REG_STATUS && wdata[`STAT_BTN_BIT])
        btn_evt_r <= 1'b0;
    end
  end

  // Millisecond tick shared by the watchdog
  assign ms_tick = (ms_cnt_r == MS_CYCLES - 32'h1);
  always_ff @(posedge mclk)
  begin
    if (reset || ms_tick)
      ms_cnt_r <= 32'h0000_0000;
    else
      ms_cnt_r <= ms_cnt_r + 32'h1;
  end

  // Two-stage watchdog: warning first, then a module reset; no NMI action
  assign wdt_run = wdt_ctrl_r[`WDT_EN_BIT] && (state_r == pwr_pkg::PS_ON);
  always_ff @(posedge mclk)
  begin
    if (reset || !wdt_run || cmd == pwr_pkg::CMD_KICK)
    begin
      wdt_cnt_r    <= 16'h0000;
      wdt_stage2_r <= 1'b0;
      wdt_fire_r   <= 1'b0;
    end
    else if (ms_tick)
    begin
      wdt_fire_r <= 1'b0;
      if (wdt_cnt_r == wdt_ctrl_r[`WDT_TIMEOUT_LSB +: 16])
      begin
        wdt_cnt_r    <= 16'h0000;
        wdt_stage2_r <= !wdt_stage2_r;
        wdt_fire_r   <= wdt_stage2_r;
      end
      else
        wdt_cnt_r <= wdt_cnt_r + 16'h0001;
    end
  end

  // Warning flag, sticky until cleared by write one; a kick does not clear it
  always_ff @(posedge mclk)
  begin
    if (reset)
      wdt_warn_r <= 1'b0;
    else if (wdt_run && ms_tick && !wdt_stage2_r &&
             wdt_cnt_r == wdt_ctrl_r[`WDT_TIMEOUT_LSB +: 16])
      wdt_warn_r <= 1'b1;
    else if (wr && addr == `REG_STATUS && wdata[`STAT_WARN_BIT])
      wdt_warn_r <= 1'b0;
  end

  // Supply and module reset outputs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      supply_on_n    <= 1'b1;
      module_reset_n <= 1'b0;
    end
    else
    begin
      supply_on_n    <= (state_r != pwr_pkg::PS_ON);
      module_reset_n <= (state_r == pwr_pkg::PS_ON) && pg_f && !wdt_fire_r;
    end
  end

  // Fan PWM; the divider keeps the carrier in the tens of kilohertz
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pwm_div_r     <= 8'h00;
      pwm_cnt_r     <= 8'h00;
      fan_drive_out <= 1'b0;
    end
    else
    begin
      pwm_div_r     <= (pwm_div_r == `PWM_DIV - 8'h01) ? 8'h00 : pwm_div_r + 8'h01;
      pwm_cnt_r     <= (pwm_div_r == `PWM_DIV - 8'h01) ? pwm_cnt_r + 8'h01 : pwm_cnt_r;
      fan_drive_out <= (pwm_cnt_r < ctrl_r[`CTRL_DUTY_LSB +: 8]);
    end
  end

  // Tach pulse count per window, scaled for two pulses per revolution
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      win_cnt_r   <= 32'h0000_0000;
      pulse_cnt_r <= 16'h0000;
      rpm_r       <= 16'h0000;
    end
    else if (win_cnt_r == RPM_WINDOW - 32'h1)
    begin
      win_cnt_r   <= 32'h0000_0000;
      pulse_cnt_r <= 16'h0000;
      rpm_r       <= 16'(pulse_cnt_r * RPM_SCALE);
    end
    else
    begin
      win_cnt_r   <= win_cnt_r + 32'h1;
      pulse_cnt_r <= pulse_cnt_r + {15'h0000, (tach_prev_r && !tach_f)};
    end
  end

  // Register read port: data in the cycle after the strobe only
  always_ff @(posedge mclk)
  begin
    if (reset || !rd)
      rdata <= 32'h0000_0000;
    else
    begin
      unique case (addr)
        `REG_CTRL:    rdata <= ctrl_r;
        `REG_STATUS:  rdata <= {24'h000000, wdt_warn_r, mon_active_r, btn_evt_r,
                                loss_r, last_on_r, state_r};
        `REG_FAN_RPM: rdata <= {16'h0000, rpm_r};
        `REG_WDT:     rdata <= wdt_ctrl_r;
        default:      rdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_reset_held_pg: assert property (!pg_f |=> !module_reset_n)
    else $error("module released from reset while power good low");
  a_supply_follows_on: assert property (
      (state_r == pwr_pkg::PS_ON) ##1 (state_r == pwr_pkg::PS_ON) |-> !supply_on_n)
    else $error("supply request missing while on");
  a_button_turns_on: assert property (
      (state_r == pwr_pkg::PS_OFF) && btn_press && sb_f |=> state_r == pwr_pkg::PS_ON)
    else $error("button press did not power on");
  a_monitor_policy: assert property (
      shutdown_evt && policy != pwr_pkg::POL_LAST |=> !mon_active_r)
    else $error("monitor started outside last-state policy");
  a_monitor_expiry: assert property (
      mon_active_r && sb_f && mon_cnt_r == MONITOR_CYCLES - 32'h1 |=> !last_on_r)
    else $error("proper switch-off not recorded at monitor end");
  a_loss_keeps_on: assert property (
      mon_active_r && !sb_f |=> last_on_r && loss_r)
    else $error("loss inside monitor not recorded as on");
  a_policy_on: assert property (
      state_r == pwr_pkg::PS_G3 && sb_f && rail_en && policy == pwr_pkg::POL_ON
      |=> state_r == pwr_pkg::PS_ON)
    else $error("turn-on policy not applied");
  a_no_rail: assert property (
      state_r == pwr_pkg::PS_G3 && sb_f && !rail_en |=> state_r == pwr_pkg::PS_ON)
    else $error("policy acted without standby rail");
  a_deep_return: assert property (
      state_r == pwr_pkg::PS_DEEP && (btn_press || wake_rise) && sb_f && deep_from_sleep_r
      |=> state_r == pwr_pkg::PS_SLEEP)
    else $error("deep sleep did not return to sleep");
  a_esoff_wake_set: assert property (
      state_r == pwr_pkg::PS_ESOFF && sb_f && !btn_press && !slp_press && !alert_fall
      |=> state_r == pwr_pkg::PS_ESOFF)
    else $error("enhanced soft-off left on a foreign event");
  a_fan_duty_zero: assert property (
      ctrl_r[`CTRL_DUTY_LSB +: 8] == 8'h00 ##1 ctrl_r[`CTRL_DUTY_LSB +: 8] == 8'h00
      |=> !fan_drive_out)
    else $error("fan driven with zero duty");
  a_wdt_two_stage: assert property ($rose(wdt_fire_r) |-> $past(wdt_stage2_r))
    else $error("watchdog fired without warning stage");
  a_rpm_scale: assert property (
      win_cnt_r == RPM_WINDOW - 32'h1 |=> rpm_r == 16'($past(pulse_cnt_r) * RPM_SCALE))
    else $error("fan speed not scaled for two pulses");

  c_power_on: cover property (state_r == pwr_pkg::PS_OFF ##1 state_r == pwr_pkg::PS_ON);
  c_deep_sleep: cover property (state_r == pwr_pkg::PS_DEEP ##1 state_r == pwr_pkg::PS_SLEEP);
  c_loss_in_mon: cover property (mon_active_r && !sb_f);
  c_esoff_wake: cover property (state_r == pwr_pkg::PS_ESOFF ##1 state_r == pwr_pkg::PS_ON);

endmodule // module_power_control

`default_nettype wire

// ===== bench/carrier_model.sv
// Carrier board model: power good driver, push-button and fan tachometer
`timescale 1ns/1ps
`default_nettype none

module carrier_model #(
  parameter int BTN_CYCLES  = 150,
  parameter int TACH_PERIOD = 40
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pg_hold,
  input  wire logic press,
  input  wire logic tach_en,
  output logic      power_good_input,
  output logic      power_button_n,
  output logic      fan_speed_in
);
  int btn_cnt;
  int tach_cnt;

  // Held low until boot is safe, then released; the model then drives it high
  assign power_good_input = pg_hold ? 1'b0 : 1'b1;

  // Momentary debounced press to ground, one clean low pulse per request
  always_ff @(posedge mclk)
  begin
    if (reset)
      btn_cnt <= 0;
    else if (press)
      btn_cnt <= BTN_CYCLES;
    else if (btn_cnt != 0)
      btn_cnt <= btn_cnt - 1;
  end
  assign power_button_n = (btn_cnt == 0);

  // Two pulses per revolution; the period divides the window so counts are exact
  always_ff @(posedge mclk)
  begin
    if (reset || !tach_en)
      tach_cnt <= 0;
    else
      tach_cnt <= (tach_cnt == TACH_PERIOD - 1) ? 0 : tach_cnt + 1;
  end
  assign fan_speed_in = !tach_en || (tach_cnt < TACH_PERIOD / 2);
endmodule // carrier_model

`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the module power control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        standby_ok = 1'b0;
  logic        sleep_button_n = 1'b1;
  logic        smbus_alert_n = 1'b1;
  logic        wake_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pg_hold = 1'b1;
  logic        press = 1'b0;
  logic        tach_en = 1'b0;
  wire         power_good_input;
  wire         power_button_n;
  wire         fan_speed_in;
  wire [31:0]  rdata;
  wire         supply_on_n;
  wire         module_reset_n;
  wire         fan_drive_out;
  int          mismatches = 0;
  int          checks = 0;
  logic [31:0] v;

  always #5 mclk = ~mclk;

  module_power_control #(
    .MONITOR_CYCLES (32'd2000),
    .MS_CYCLES      (32'd10),
    .RPM_WINDOW     (32'd1000)
  ) u_module_power_control (
    .mclk(mclk), .reset(reset), .standby_ok(standby_ok),
    .power_good_input(power_good_input), .power_button_n(power_button_n),
    .sleep_button_n(sleep_button_n), .smbus_alert_n(smbus_alert_n),
    .wake_in(wake_in), .fan_speed_in(fan_speed_in), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .supply_on_n(supply_on_n),
    .module_reset_n(module_reset_n), .fan_drive_out(fan_drive_out)
  );

  carrier_model u_carrier_model (
    .mclk(mclk), .reset(reset), .pg_hold(pg_hold), .press(press), .tach_en(tach_en),
    .power_good_input(power_good_input), .power_button_n(power_button_n),
    .fan_speed_in(fan_speed_in)
  );

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; the next access always starts on a fresh edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Pin changes pass a long filter, so poll the state field under a bound
  task automatic wait_state(input logic [2:0] exp);
    for (int i = 0; i < 80; i++)
    begin
      reg_rd(8'h08, v);
      if (v[2:0] === exp)
        return;
      repeat (8) @(posedge mclk);
    end
    check({29'h0, v[2:0]}, {29'h0, exp});
    tally_and_finish();
  endtask

  // Pulse wake (0), alert (1) or sleep button (2); the quiet tail lets the filter see release
  task automatic pin_pulse(input int pin);
    @(posedge mclk);
    if (pin == 0) wake_in <= 1'b1;
    else if (pin == 1) smbus_alert_n <= 1'b0;
    else sleep_button_n <= 1'b0;
    repeat (150) @(posedge mclk);
    wake_in <= 1'b0;
    smbus_alert_n <= 1'b1;
    sleep_button_n <= 1'b1;
    repeat (150) @(posedge mclk);
  endtask

  task automatic t_regs();
    reg_rd(8'h00, v); check(v, 32'h0000_8004);
    reg_rd(8'h10, v); check(v, 32'h0);
    reg_rd(8'h3c, v); check(v, 32'h0);
  endtask

  task automatic t_power_on();
    @(posedge mclk) standby_ok <= 1'b1;
    wait_state(3'h1);
    check({31'h0, supply_on_n}, 32'h1);
    @(posedge mclk) press <= 1'b1;
    @(posedge mclk) press <= 1'b0;
    wait_state(3'h2);
    check({30'h0, supply_on_n, module_reset_n}, 32'h0);
    repeat (40) @(posedge mclk);
    check({31'h0, module_reset_n}, 32'h0);
    @(posedge mclk) pg_hold <= 1'b0;
    repeat (130) @(posedge mclk);
    #1 check({31'h0, module_reset_n}, 32'h1);
  endtask

  task automatic t_sleep_deep();
    reg_wr(8'h04, 32'h2); wait_state(3'h3);
    reg_wr(8'h04, 32'h3); wait_state(3'h4);
    check({31'h0, supply_on_n}, 32'h1);
    pin_pulse(1'b0); wait_state(3'h3);
    pin_pulse(1'b0); wait_state(3'h2);
  endtask

  task automatic t_soft_off();
    reg_wr(8'h04, 32'h1); wait_state(3'h1);
    reg_rd(8'h08, v); check({31'h0, v[6]}, 32'h0);
    reg_wr(8'h04, 32'h4); wait_state(3'h5);
    pin_pulse(1'b0);
    repeat (20) @(posedge mclk);
    reg_rd(8'h08, v); check({29'h0, v[2:0]}, 32'h5);
    pin_pulse(1'b1); wait_state(3'h2);
    reg_wr(8'h04, 32'h1); wait_state(3'h1);
    reg_wr(8'h04, 32'h4); wait_state(3'h5);
    pin_pulse(2); wait_state(3'h2);
  endtask

  task automatic t_loss();
    reg_wr(8'h00, 32'h0000_8006);
    reg_wr(8'h04, 32'h1); wait_state(3'h1);
    reg_rd(8'h08, v); check({31'h0, v[6]}, 32'h1);
    @(posedge mclk) standby_ok <= 1'b0;
    wait_state(3'h0);
    check({30'h0, v[4:3]}, 32'h3);
    @(posedge mclk) standby_ok <= 1'b1;
    wait_state(3'h2);
    #1 check({31'h0, supply_on_n}, 32'h0);
    reg_wr(8'h04, 32'h1); wait_state(3'h1);
    repeat (2050) @(posedge mclk);
    reg_rd(8'h08, v); check({30'h0, v[6], v[3]}, 32'h0);
  endtask

  // Standby drop and return must end powered on under the given control word
  task automatic bounce(input logic [31:0] c);
    reg_wr(8'h00, c);
    @(posedge mclk) standby_ok <= 1'b0;
    wait_state(3'h0);
    @(posedge mclk) standby_ok <= 1'b1;
    wait_state(3'h2);
    #1 check({31'h0, supply_on_n}, 32'h0);
  endtask

  task automatic t_policy();
    bounce(32'h0000_8005);
    bounce(32'h0000_8000);
  endtask

  // With the software bit set a press only raises the flag; state stays on
  task automatic t_button_sw();
    reg_wr(8'h00, 32'h0000_800e);
    @(posedge mclk) press <= 1'b1;
    @(posedge mclk) press <= 1'b0;
    repeat (300) @(posedge mclk);
    reg_rd(8'h08, v); check({28'h0, v[5], v[2:0]}, 32'h0000_000a);
    reg_wr(8'h08, 32'h20);
    reg_rd(8'h08, v); check({31'h0, v[5]}, 32'h0);
  endtask

  // Stage is three 10-cycle ticks: warning near 30 cycles, one-tick reset near 60
  task automatic t_watchdog();
    int low;
    low = 0;
    reg_wr(8'h10, 32'h0002_0001);
    repeat (35) @(posedge mclk);
    reg_rd(8'h08, v); check({31'h0, v[7]}, 32'h1);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      #1 low += !module_reset_n;
    end
    check(32'(low), 32'd10);
    reg_wr(8'h10, 32'h0);
    reg_wr(8'h08, 32'h80);
    reg_wr(8'h10, 32'h0002_0001);
    repeat (6)
    begin
      repeat (10) @(posedge mclk);
      reg_wr(8'h04, 32'h5);
    end
    reg_wr(8'h10, 32'h0);
    reg_rd(8'h08, v); check({30'h0, v[7], module_reset_n}, 32'h1);
  endtask

  task automatic t_fan();
    int high;
    high = 0;
    repeat (4096)
    begin
      @(posedge mclk);
      #1 high += fan_drive_out;
    end
    check(32'(high), 32'd2048);
    @(posedge mclk) tach_en <= 1'b1;
    repeat (2600) @(posedge mclk);
    reg_rd(8'h0c, v); check({16'h0, v[15:0]}, 32'd750);
    reg_wr(8'h00, 32'h0000_000e);
    repeat (3) @(posedge mclk);
    #1 check({31'h0, fan_drive_out}, 32'h0);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_power_on();
    t_sleep_deep();
    t_soft_off();
    t_loss();
    t_policy();
    t_button_sw();
    t_watchdog();
    t_fan();
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
